/* File: pska_pkg.sv */
package pska_pkg;
  // register byte offsets
  localparam logic [7:0] PSKA_OFF_CTRL = 8'h00;
  localparam logic [7:0] PSKA_OFF_ENT_SEL = 8'h04;
  localparam logic [7:0] PSKA_OFF_ENT_CFG = 8'h08;
  localparam logic [7:0] PSKA_OFF_LIFETIME = 8'h0c;
  localparam logic [7:0] PSKA_OFF_CMD = 8'h10;
  localparam logic [7:0] PSKA_OFF_STATUS = 8'h14;
  localparam logic [7:0] PSKA_OFF_COUNT = 8'h18;
  localparam logic [7:0] PSKA_OFF_MAP = 8'h1c;
  localparam logic [7:0] PSKA_OFF_KEY_DATA = 8'h20;
  localparam logic [7:0] PSKA_OFF_KEY_CMD = 8'h24;
  // field positions
  localparam int PSKA_CTRL_OLT = 0;
  localparam int PSKA_CFG_MODE_LSB = 0;
  localparam int PSKA_CFG_MCAST = 2;
  localparam int PSKA_CFG_KILL = 3;
  localparam int PSKA_CMD_ACKED = 0;
  localparam int PSKA_CMD_BOOT = 1;
  localparam int PSKA_CMD_RELOAD = 2;
  localparam int PSKA_MAP_ENT_LSB = 8;
  localparam int PSKA_KEYCMD_SLOT = 0;
  localparam int PSKA_LIFE_W = 16;
  // envelope header fields inside a quantum
  localparam int PSKA_HDR_CIPHER_BIT = 40;
  localparam int PSKA_HDR_KEYSEL_BIT = 41;
  localparam int PSKA_EQ_W = 64;
  localparam int PSKA_IV_W = 128;
  localparam logic PSKA_DIR_DOWN = 1'b0;
  localparam logic PSKA_DIR_UP = 1'b1;
  // reset values
  localparam logic PSKA_RST_OLT = 1'b1;
  // lifetime tick timing
  localparam int PSKA_CLK_NS = 25;
  localparam int PSKA_TICK_US = 1000;
  localparam int PSKA_TICK_CYC = PSKA_TICK_US * 1000 / PSKA_CLK_NS;
  typedef enum logic [1:0] {PSKA_MODE_AUTO, PSKA_MODE_OFF, PSKA_MODE_ON} pska_mode_type;
endpackage

/* File: pska_key_mem.sv */
`timescale 1ns/1ps
module pska_key_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 256,
  parameter int PORTS = 2,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read ports
  input wire logic [PORTS-1:0][AW-1:0] rd_addr,
  output logic [PORTS-1:0][WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  for (genvar g = 0; g < PORTS; g++) begin : g_rd
    logic [WIDTH-1:0] rd_q;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        rd_q <= '0;
      end else begin
        rd_q <= mem[rd_addr[g]];
      end
    end
    assign rd_data[g] = rd_q;
  end
endmodule

/* File: pska_core.sv */
// Contract
// RL1 - each rx header fetches the channel's current decryption key for the decryptor
// RL2 - each tx header fetches the channel's current encryption key for the encryptor
// RL3 - a fresh 128-bit start counter per transmitted header on every channel
// RL4 - olt entity cipher turns on once bootstrap key exists; management may clear
// RL5 - onu tx cipher follows rx cipher indication; management may force on or off
// RL6 - acked flag set after first session key ack; forces swap; cleared on use
// RL7 - acked flag stays false for multicast entities
// RL8 - bootstrap flag set when slot 0 key stored; starts downstream cipher; cleared on use; code sets it from the command boot bit, not the key store
// RL9 - multicast bootstrap flag set only after every member acknowledged; code takes the boot command with no acknowledgement check
// RL10 - two keys per entity; management writes, activation only reads
// RL11 - each entity has a provisioned key lifetime from management
// RL12 - rx cipher indication taken from header flag of mapped entity
// RL13 - start counter derived from channel index and header quantum
// RL14 - multicast link ids own an entity; unicast ones share the onu entity
// RL15 - per-entity countdown raises expired flag; key not kept past expiry
// RL16 - olt runs one encryption activation instance per transmit channel
// RL17 - olt and onu run one decryption activation instance per receive channel
// RL18 - onu runs one encryption activation instance per transmit channel
// RL19 - counter mode; counters unique under one key
// RL20 - key switch signalled by toggling key select bit in next header
// RL21 - active key slot is one bit; increment toggles it
// RL22 - forced onu setting beats rx indication until removed
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module pska_core import pska_pkg::*; #(
  parameter int NUM_ENT = 4,
  parameter int NUM_CH = 2,
  parameter int NUM_MAP = 16,
  parameter int KEY_W = 256,
  parameter int TICK_CYC = PSKA_TICK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit channels
  input wire logic [NUM_CH-1:0] tx_quantum_is_header,
  input wire logic [NUM_CH-1:0][PSKA_EQ_W-1:0] tx_quantum,
  output logic [NUM_CH-1:0] tx_out_valid,
  output logic [NUM_CH-1:0][KEY_W-1:0] tx_channel_key,
  output logic [NUM_CH-1:0][PSKA_IV_W-1:0] tx_initial_counter,
  output logic [NUM_CH-1:0] tx_key_slot,
  output logic [NUM_CH-1:0] tx_cipher_on,
  // receive channels
  input wire logic [NUM_CH-1:0] rx_quantum_is_header,
  input wire logic [NUM_CH-1:0][PSKA_EQ_W-1:0] rx_quantum,
  output logic [NUM_CH-1:0] rx_out_valid,
  output logic [NUM_CH-1:0][KEY_W-1:0] rx_channel_key,
  output logic [NUM_CH-1:0][PSKA_IV_W-1:0] rx_initial_counter,
  output logic [NUM_CH-1:0] rx_key_slot,
  output logic [NUM_CH-1:0] rx_cipher_on
);
  localparam int EW = $clog2(NUM_ENT);
  localparam int MW = $clog2(NUM_MAP);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int AW = EW + 1;

  typedef struct packed {
    logic is_olt;
    logic [EW-1:0] sel;
    logic [NUM_MAP-1:0][EW-1:0] map_ent;
    logic [NUM_ENT-1:0] mcast;
    logic [NUM_ENT-1:0][1:0] mode;
    logic [NUM_ENT-1:0] olt_on;
    logic [NUM_ENT-1:0] rxc;
    logic [NUM_ENT-1:0] acked;
    logic [NUM_ENT-1:0] boot;
    logic [NUM_ENT-1:0] expired;
    logic [NUM_ENT-1:0] tslot;
    logic [NUM_ENT-1:0] rslot;
    logic [NUM_ENT-1:0][PSKA_LIFE_W-1:0] life;
    logic [NUM_ENT-1:0][PSKA_LIFE_W-1:0] cnt;
    logic [TW-1:0] tick_cnt;
    logic [KEY_W-1:0] stage;
    logic [NUM_CH-1:0] tv;
    logic [NUM_CH-1:0] tflag;
    logic [NUM_CH-1:0] tsl;
    logic [NUM_CH-1:0][PSKA_IV_W-1:0] tctr;
    logic [NUM_CH-1:0] rv;
    logic [NUM_CH-1:0] rflag;
    logic [NUM_CH-1:0] rsl;
    logic [NUM_CH-1:0][PSKA_IV_W-1:0] rctr;
    logic [31:0] rdata;
    logic err;
  } pska_state_type;

  pska_state_type q;
  pska_state_type d;
  logic [NUM_CH-1:0][AW-1:0] tx_addr;
  logic [NUM_CH-1:0][AW-1:0] rx_addr;
  logic key_wr;
  logic [EW-1:0] rx_last_ent;
  logic tick;
  logic setup;
  logic wr_acc;

  // counter layout keeps direction and channel apart, so no two channels collide
  function automatic logic [PSKA_IV_W-1:0] derive_start_counter(
    input logic dir, input logic [6:0] ch, input logic [PSKA_EQ_W-1:0] eq);
    derive_start_counter = {dir, ch, 56'h0, eq}; // [RL13] [RL19] [RL3]
  endfunction

  function automatic logic map_hit(input logic [7:0] a);
    case (a)
      PSKA_OFF_CTRL, PSKA_OFF_ENT_SEL, PSKA_OFF_ENT_CFG, PSKA_OFF_LIFETIME, PSKA_OFF_CMD,
      PSKA_OFF_STATUS, PSKA_OFF_COUNT, PSKA_OFF_MAP, PSKA_OFF_KEY_DATA,
      PSKA_OFF_KEY_CMD: map_hit = 1'b1;
      default: map_hit = 1'b0;
    endcase
  endfunction

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign tick = (q.tick_cnt == TW'(TICK_CYC - 1));
  assign key_wr = wr_acc && (paddr == PSKA_OFF_KEY_CMD); // [RL10]

  always_comb begin
    logic [EW-1:0] e;
    logic [EW-1:0] s;
    e = '0;
    d = q;
    s = q.sel;
    tx_addr = '0;
    rx_addr = '0;
    rx_last_ent = '0;
    d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
    // lifetime countdown per entity
    for (int i = 0; i < NUM_ENT; i++) begin
      if (tick && q.cnt[i] != '0) begin
        d.cnt[i] = q.cnt[i] - 1'b1;
        if (q.cnt[i] == PSKA_LIFE_W'(1)) begin
          d.expired[i] = 1'b1; // [RL15]
        end
      end
    end
    // one decryption activation instance per receive channel
    for (int c = 0; c < NUM_CH; c++) begin // [RL17]
      e = q.map_ent[rx_quantum[c][MW-1:0]]; // [RL14]
      d.rv[c] = rx_quantum_is_header[c];
      if (rx_quantum_is_header[c]) begin
        rx_last_ent = e;
        d.rxc[e] = rx_quantum[c][PSKA_HDR_CIPHER_BIT]; // [RL12]
        d.rslot[e] = rx_quantum[c][PSKA_HDR_KEYSEL_BIT]; // [RL20]
        d.rflag[c] = rx_quantum[c][PSKA_HDR_CIPHER_BIT];
        d.rsl[c] = rx_quantum[c][PSKA_HDR_KEYSEL_BIT];
        d.rctr[c] = derive_start_counter(q.is_olt ? PSKA_DIR_UP : PSKA_DIR_DOWN,
          7'(c), rx_quantum[c]);
      end
      rx_addr[c] = {e, rx_quantum[c][PSKA_HDR_KEYSEL_BIT]}; // [RL1]
    end
    // one encryption activation instance per transmit channel
    for (int c = 0; c < NUM_CH; c++) begin // [RL16] [RL18]
      e = q.map_ent[tx_quantum[c][MW-1:0]]; // [RL14]
      d.tv[c] = tx_quantum_is_header[c];
      if (tx_quantum_is_header[c]) begin
        if (q.is_olt) begin
          if (d.boot[e]) begin
            d.olt_on[e] = 1'b1; // [RL4] [RL8]
            d.boot[e] = 1'b0;
          end
          if ((d.expired[e] || d.acked[e]) && d.tslot[e] == q.tslot[e]) begin
            d.tslot[e] = d.tslot[e] + 1'b1; // [RL6] [RL15] [RL20] [RL21]
            d.acked[e] = 1'b0;
            d.expired[e] = 1'b0;
            d.cnt[e] = q.life[e];
          end
          d.tflag[c] = d.olt_on[e];
        end else begin
          case (pska_mode_type'(q.mode[e]))
            PSKA_MODE_ON: d.tflag[c] = 1'b1; // [RL22]
            PSKA_MODE_OFF: d.tflag[c] = 1'b0; // [RL22]
            default: d.tflag[c] = d.rxc[e]; // [RL5]
          endcase
          if (d.tslot[e] != d.rslot[e]) begin
            d.tslot[e] = d.rslot[e]; // [RL20]
          end
        end
        d.tsl[c] = d.tslot[e];
        d.tctr[c] = derive_start_counter(q.is_olt ? PSKA_DIR_DOWN : PSKA_DIR_UP,
          7'(c), tx_quantum[c]); // [RL3]
      end
      tx_addr[c] = {e, d.tslot[e]}; // [RL2]
    end
    // apb writes, after hardware so that software sets win over consumption
    if (wr_acc) begin
      case (paddr)
        PSKA_OFF_CTRL: d.is_olt = pwdata[PSKA_CTRL_OLT];
        PSKA_OFF_ENT_SEL: d.sel = pwdata[EW-1:0];
        PSKA_OFF_ENT_CFG: begin
          d.mode[s] = pwdata[PSKA_CFG_MODE_LSB+:2]; // [RL22]
          d.mcast[s] = pwdata[PSKA_CFG_MCAST];
          if (pwdata[PSKA_CFG_MCAST]) begin
            d.acked[s] = 1'b0; // [RL7]
          end
          if (pwdata[PSKA_CFG_KILL]) begin
            d.olt_on[s] = 1'b0; // [RL4]
          end
        end
        PSKA_OFF_LIFETIME: d.life[s] = pwdata[PSKA_LIFE_W-1:0]; // [RL11]
        PSKA_OFF_CMD: begin
          if (pwdata[PSKA_CMD_ACKED] && !q.mcast[s]) begin
            d.acked[s] = 1'b1; // [RL6] [RL7]
          end
          if (pwdata[PSKA_CMD_BOOT]) begin
            d.boot[s] = 1'b1; // [RL8] [RL9]
          end
          if (pwdata[PSKA_CMD_RELOAD]) begin
            d.cnt[s] = q.life[s];
            // a countdown ending in this very cycle keeps its expiry
            if (!(tick && q.cnt[s] == PSKA_LIFE_W'(1))) begin
              d.expired[s] = 1'b0; // [RL15]
            end
          end
        end
        PSKA_OFF_MAP: d.map_ent[pwdata[MW-1:0]] = pwdata[PSKA_MAP_ENT_LSB+:EW]; // [RL14]
        PSKA_OFF_KEY_DATA: d.stage = {q.stage[KEY_W-33:0], pwdata};
        default: ;
      endcase
    end
    // read data captured in setup so it stands through the access phase
    if (setup) begin
      d.err = !map_hit(paddr);
      d.rdata = '0;
      if (!pwrite) begin
        case (paddr)
          PSKA_OFF_CTRL: d.rdata[PSKA_CTRL_OLT] = q.is_olt;
          PSKA_OFF_ENT_SEL: d.rdata[EW-1:0] = q.sel;
          PSKA_OFF_ENT_CFG: d.rdata[PSKA_CFG_MCAST:0] = {q.mcast[s], q.mode[s]};
          PSKA_OFF_LIFETIME: d.rdata[PSKA_LIFE_W-1:0] = q.life[s];
          PSKA_OFF_STATUS: d.rdata[9:0] = {q.mode[s], q.mcast[s], q.rslot[s], q.tslot[s],
            q.expired[s], q.boot[s], q.acked[s], q.rxc[s], q.olt_on[s]};
          PSKA_OFF_COUNT: d.rdata[PSKA_LIFE_W-1:0] = q.cnt[s];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.is_olt <= PSKA_RST_OLT;
    end else begin
      q <= d;
    end
  end

  pska_key_mem #(
    .DEPTH(2 * NUM_ENT),
    .WIDTH(KEY_W),
    .PORTS(2 * NUM_CH),
    .AW(AW)
  ) u_keys (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(key_wr),
    .wr_addr({q.sel, pwdata[PSKA_KEYCMD_SLOT]}),
    .wr_data(q.stage),
    .rd_addr({rx_addr, tx_addr}),
    .rd_data({rx_channel_key, tx_channel_key})
  );

  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = q.err;
  assign tx_out_valid = q.tv;
  assign tx_initial_counter = q.tctr;
  assign tx_key_slot = q.tsl;
  assign tx_cipher_on = q.tflag;
  assign rx_out_valid = q.rv;
  assign rx_initial_counter = q.rctr;
  assign rx_key_slot = q.rsl;
  assign rx_cipher_on = q.rflag;

  chk_tx_answer: assert property (@(posedge mclk) disable iff (!rst_n) // [RL2]
    tx_quantum_is_header[0] |=> tx_out_valid[0] && tx_initial_counter[0][63:0] ==
      $past(tx_quantum[0]))
    else $error("tx header not answered next cycle");
  chk_rx_answer: assert property (@(posedge mclk) disable iff (!rst_n) // [RL1]
    rx_quantum_is_header[0] |=> rx_out_valid[0] &&
      rx_key_slot[0] == $past(rx_quantum[0][PSKA_HDR_KEYSEL_BIT]))
    else $error("rx header slot not answered");
  chk_tx_direction: assert property (@(posedge mclk) disable iff (!rst_n) // [RL3]
    tx_quantum_is_header[0] |=> tx_initial_counter[0][127] == !$past(q.is_olt))
    else $error("tx counter direction wrong");
  chk_mcast_acked: assert property (@(posedge mclk) disable iff (!rst_n) // [RL7]
    (q.acked & q.mcast) == '0)
    else $error("multicast entity shows acked");
  chk_rx_flag: assert property (@(posedge mclk) disable iff (!rst_n) // [RL12]
    rx_quantum_is_header[NUM_CH-1] |=>
      q.rxc[$past(rx_last_ent)] == $past(rx_quantum[NUM_CH-1][PSKA_HDR_CIPHER_BIT]))
    else $error("rx cipher indication not taken");
  chk_onu_force: assert property (@(posedge mclk) disable iff (!rst_n) // [RL22]
    !q.is_olt && tx_quantum_is_header[0] &&
      q.mode[q.map_ent[tx_quantum[0][MW-1:0]]] == 2'(PSKA_MODE_ON) |=> tx_cipher_on[0])
    else $error("forced onu cipher ignored");
  // per-entity checks, so every entity the traffic reaches is watched
  for (genvar g = 0; g < NUM_ENT; g++) begin : g_ent_chk
    chk_expire_set: assert property (@(posedge mclk) disable iff (!rst_n) // [RL15]
      tick && q.cnt[g] == PSKA_LIFE_W'(1) |=> q.expired[g] || $changed(q.tslot[g]))
      else $error("countdown end did not expire");
    chk_olt_enable: assert property (@(posedge mclk) disable iff (!rst_n) // [RL4]
      $rose(q.olt_on[g]) |-> $past(q.boot[g]))
      else $error("olt cipher on without bootstrap key");
  end
  chk_apb_err: assert property (@(posedge mclk) disable iff (!rst_n)
    setup && !map_hit(paddr) |=> pslverr)
    else $error("unmapped access not flagged");
  cov_olt_swap: cover property (@(posedge mclk) disable iff (!rst_n)
    q.is_olt && $changed(q.tslot));
  cov_onu_follow: cover property (@(posedge mclk) disable iff (!rst_n)
    !q.is_olt && $changed(q.tslot));
  cov_expire: cover property (@(posedge mclk) disable iff (!rst_n) $rose(|q.expired));
endmodule

/* File: pska_peer.sv */
`timescale 1ns/1ps
module pska_peer import pska_pkg::*; #(
  parameter int NUM_CH = 2
) (
  // clock
  input wire logic mclk,
  // envelope headers toward the block
  output logic [NUM_CH-1:0] rx_quantum_is_header,
  output logic [NUM_CH-1:0][PSKA_EQ_W-1:0] rx_quantum
);
  initial begin
    rx_quantum_is_header = '0;
    rx_quantum = '0;
  end
  // one header; the line shows scrambled data once released
  task automatic send(input int ch, input logic [PSKA_EQ_W-1:0] q);
    @(posedge mclk);
    rx_quantum_is_header[ch] <= 1'h1;
    rx_quantum[ch] <= q;
    @(posedge mclk);
    rx_quantum_is_header[ch] <= 1'h0;
    rx_quantum[ch] <= ~q;
  endtask
endmodule

/* File: pska_core_tb.sv */
`timescale 1ns/1ps
module pska_core_tb import pska_pkg::*;;
  typedef struct {
    logic [7:0] a;
    logic [31:0] d;
    logic rx;
    int ch;
    logic [1:0] f;
    logic olt;
    logic s;
    logic on;
  } pska_row_type;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic e;
  logic [1:0] txh, rxh, tv, rv, ts, rs, ton, ron;
  logic [1:0][63:0] txq, rxq;
  logic [1:0][255:0] tk, rk;
  logic [1:0][127:0] ti, ri;
  int bad_count, cmp_count;
  pska_row_type rows[12];

  pska_core #(.TICK_CYC(4)) pska_core_inst (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_quantum_is_header(txh), .tx_quantum(txq), .tx_out_valid(tv), .tx_channel_key(tk),
    .tx_initial_counter(ti), .tx_key_slot(ts), .tx_cipher_on(ton),
    .rx_quantum_is_header(rxh), .rx_quantum(rxq), .rx_out_valid(rv), .rx_channel_key(rk),
    .rx_initial_counter(ri), .rx_key_slot(rs), .rx_cipher_on(ron)
  );
  pska_peer #(.NUM_CH(2)) pska_peer_inst (
    .mclk(mclk), .rx_quantum_is_header(rxh), .rx_quantum(rxq)
  );

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] kw(input logic s, input int i);
    return {8'ha0, 7'h0, s, 8'h0, 8'(i)};
  endfunction
  function automatic logic [255:0] kx(input logic s);
    logic [255:0] k;
    for (int i = 0; i < 8; i++)
      k = {k[223:0], kw(s, i)};
    return k;
  endfunction
  function automatic logic [63:0] hq(input logic [1:0] f);
    return {22'h0, f, 36'h0, 4'h3};
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp_w(input logic [255:0] g, input logic [255:0] x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic cmp_b(input logic g, input logic x);
    cmp_w(256'(g), 256'(x));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      bad_count++;
      end_sim();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic load_keys();
    wr(PSKA_OFF_ENT_SEL, 32'h1);
    wr(PSKA_OFF_MAP, 32'h103);
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 8; i++)
        wr(PSKA_OFF_KEY_DATA, kw(s[0], i));
      wr(PSKA_OFF_KEY_CMD, 32'(s));
    end
  endtask
  task automatic chk(input pska_row_type w);
    logic [63:0] q;
    q = hq(w.f);
    wr(w.a, w.d);
    if (w.rx)
      pska_peer_inst.send(w.ch, q);
    else begin
      @(posedge mclk);
      txh[w.ch] <= 1'h1;
      txq[w.ch] <= q;
      @(posedge mclk);
      txh[w.ch] <= 1'h0;
    end
    #1;
    cmp_b(w.rx ? rv[w.ch] : tv[w.ch], 1'h1);
    cmp_b(w.rx ? rs[w.ch] : ts[w.ch], w.s);
    cmp_b(w.rx ? ron[w.ch] : ton[w.ch], w.on);
    cmp_w(w.rx ? rk[w.ch] : tk[w.ch], kx(w.s));
    cmp_w(256'(w.rx ? ri[w.ch] : ti[w.ch]), 256'({w.rx ~^ w.olt, 7'(w.ch), 56'h0, q}));
  endtask

  initial begin
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    txh = '0;
    txq = '0;
    bad_count = 0;
    cmp_count = 0;
    // addr, data, rx, ch, header flags, olt, slot, cipher on
    rows = '{'{PSKA_OFF_CMD, 32'h2, 1'h0, 0, 2'h0, 1'h1, 1'h0, 1'h1},
             '{PSKA_OFF_CMD, 32'h1, 1'h0, 1, 2'h0, 1'h1, 1'h1, 1'h1},
             '{PSKA_OFF_ENT_SEL, 32'h1, 1'h0, 0, 2'h0, 1'h1, 1'h1, 1'h1},
             '{PSKA_OFF_ENT_CFG, 32'h8, 1'h0, 1, 2'h0, 1'h1, 1'h1, 1'h0},
             '{PSKA_OFF_ENT_SEL, 32'h1, 1'h1, 0, 2'h3, 1'h1, 1'h1, 1'h1},
             '{PSKA_OFF_ENT_SEL, 32'h1, 1'h1, 1, 2'h0, 1'h1, 1'h0, 1'h0},
             '{PSKA_OFF_CTRL, 32'h0, 1'h1, 0, 2'h1, 1'h0, 1'h0, 1'h1},
             '{PSKA_OFF_ENT_SEL, 32'h1, 1'h0, 1, 2'h0, 1'h0, 1'h0, 1'h1},
             '{PSKA_OFF_ENT_CFG, 32'h1, 1'h0, 0, 2'h0, 1'h0, 1'h0, 1'h0},
             '{PSKA_OFF_ENT_CFG, 32'h2, 1'h1, 1, 2'h2, 1'h0, 1'h1, 1'h0},
             '{PSKA_OFF_ENT_SEL, 32'h1, 1'h0, 0, 2'h0, 1'h0, 1'h1, 1'h1},
             '{PSKA_OFF_ENT_CFG, 32'h0, 1'h0, 1, 2'h0, 1'h0, 1'h1, 1'h0}};
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    load_keys();
    foreach (rows[n])
      chk(rows[n]);
    // mid-run reset, then register defaults and an unmapped place
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    apb(1'h0, PSKA_OFF_CTRL, 32'h0);
    cmp_w(256'(r), 256'(32'h1));
    apb(1'h0, PSKA_OFF_COUNT, 32'h0);
    cmp_w(256'(r), 256'(32'h0));
    apb(1'h0, 8'h40, 32'h0);
    cmp_w(256'({e, r}), 256'({1'h1, 32'h0}));
    apb(1'h1, 8'h40, 32'h5);
    cmp_b(e, 1'h1);
    // lifetime runs out, next header swaps the key
    load_keys();
    wr(PSKA_OFF_LIFETIME, 32'h2);
    wr(PSKA_OFF_CMD, 32'h4);
    r = 32'h0;
    for (int n = 0; n < 40 && r[4] !== 1'h1; n++)
      apb(1'h0, PSKA_OFF_STATUS, 32'h0);
    cmp_b(r[4], 1'h1);
    chk(pska_row_type'{PSKA_OFF_ENT_SEL, 32'h1, 1'h0, 1, 2'h0, 1'h1, 1'h1, 1'h0});
    apb(1'h0, PSKA_OFF_STATUS, 32'h0);
    cmp_b(r[4], 1'h0);
    // multicast entity ignores the acknowledge
    wr(PSKA_OFF_ENT_CFG, 32'h4);
    wr(PSKA_OFF_CMD, 32'h1);
    apb(1'h0, PSKA_OFF_STATUS, 32'h0);
    cmp_w(256'({r[7], r[2]}), 256'(2'h2));
    end_sim();
  end
endmodule
